// ### bench/parallel_io_tb.sv
`timescale 1ns/10ps
module parallel_io_tb;
  typedef struct packed {
    logic [2:0] port;
    logic [7:0] data;
  } row_s;
  localparam row_s ROWS [8] = '{'{3'h0, 8'hA5}, '{3'h1, 8'hFE},
    '{3'h1, 8'hFD}, '{3'h2, 8'h3C}, '{3'h3, 8'hC3}, '{3'h4, 8'h0F},
    '{3'h5, 8'hF0}, '{3'h7, 8'h81}};
  localparam logic [7:0] CTRLS [3] = '{8'h8D, 8'h7F, 8'h00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0] paddr, ext_mode, drive_en_n, in_strobe, sw8_closed, led;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0] sw3_closed;
  logic [1:0] opto_current, relay_energize;
  pio_pkg::port_bytes_t pio_in, pio_out, pio_oe_n, ext_val;
  int err_count, check_count;
  parallel_io i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pio_in, .pio_out, .pio_oe_n,
    .drive_en_n, .in_strobe, .sw3_closed, .sw8_closed, .opto_current,
    .led, .relay_energize, .irq);
  pio_ext_model i_ext (.pio_out, .pio_oe_n, .ext_mode, .ext_val,
    .drive_en_n, .pio_in);
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h got %h", name, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic port(input logic w, input logic [2:0] p, input logic [7:0] d);
    apb(w, pio_pkg::PORT_BASE + {3'h0, p, 2'h0}, d);
    @(negedge pclk);
  endtask
  task automatic chk_oe(input logic [7:0] c);
    for (int n = 0; n < 8; n++) begin
      chk("oe", ((n != 6 && c[n]) || ext_mode[n]) ? 8'h00 : 8'hFF,
          pio_oe_n[n]);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata, in_strobe, sw8_closed, ext_mode} = '0;
    {sw3_closed, opto_current} = '0;
    ext_val = {8{8'hFF}};
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("led", 8'h00, led);
    chk("relay", 2'h3, relay_energize);
    chk_oe(8'h00);
    chk("irq", 1'b0, irq);
    port(1'b0, pio_pkg::CTRL_PORT, 8'h00);
    chk("status", 8'hFF, rdata);
    foreach (ROWS[i]) begin
      port(1'b1, ROWS[i].port, ROWS[i].data);
      chk("out", ROWS[i].data, pio_out[ROWS[i].port]);
      if (ROWS[i].port == pio_pkg::RELAY_PORT)
        chk("relay", 2'(~ROWS[i].data[1:0]), relay_energize);
      if (ROWS[i].port == pio_pkg::LED_PORT)
        chk("led", ROWS[i].data, led);
    end
    foreach (CTRLS[i]) begin
      port(1'b1, pio_pkg::CTRL_PORT, CTRLS[i]);
      chk_oe(CTRLS[i]);
    end
    @(posedge pclk);
    ext_mode <= 8'h05;
    @(negedge pclk);
    chk_oe(8'h00);
    @(posedge pclk);
    sw8_closed <= 8'h3C;
    port(1'b0, pio_pkg::LED_PORT, 8'h00);
    chk("sw8", 8'hC3, rdata);
    chk("led", 8'h81, led);
    chk("out7", 8'h81, pio_out[7]);
    @(posedge pclk);
    sw3_closed <= 3'h5;
    opto_current <= 2'h1;
    port(1'b0, pio_pkg::SW_PORT, 8'h00);
    chk("port4", 8'hF2, rdata);
    @(posedge pclk);
    sw3_closed <= 3'h0;
    opto_current <= 2'h2;
    port(1'b0, pio_pkg::SW_PORT, 8'h00);
    chk("port4", 8'hEF, rdata);
    @(posedge pclk);
    ext_mode <= 8'h04;
    ext_val[0] <= 8'h5A;
    in_strobe <= 8'h01;
    @(posedge pclk);
    in_strobe <= 8'h00;
    port(1'b0, pio_pkg::CTRL_PORT, 8'h00);
    chk("status", 8'hFE, rdata);
    apb(1'b0, pio_pkg::INT_STATUS, 8'h00);
    chk("istat", 8'h01, rdata);
    apb(1'b1, pio_pkg::INT_ENABLE, 8'h01);
    @(negedge pclk);
    chk("irq", 1'b1, irq);
    apb(1'b1, pio_pkg::INT_ENABLE, 8'h00);
    @(negedge pclk);
    chk("irq", 1'b0, irq);
    apb(1'b1, pio_pkg::INT_ENABLE, 8'h01);
    apb(1'b1, pio_pkg::INT_CLEAR, 8'h01);
    @(negedge pclk);
    chk("irq", 1'b0, irq);
    port(1'b0, 3'h0, 8'h00);
    chk("in0", 8'h5A, rdata);
    port(1'b0, pio_pkg::CTRL_PORT, 8'h00);
    chk("status", 8'hFF, rdata);
    apb(1'b1, pio_pkg::INT_STATUS, 8'hFF);
    chk("err", 1'b1, rerr);
    apb(1'b0, 8'h40, 8'h00);
    chk("err", 1'b1, rerr);
    apb(1'b0, pio_pkg::INT_CLEAR, 8'h00);
    chk("err", 1'b1, rerr);
    ext_mode <= 8'h00;
    in_strobe <= 8'h08;
    port(1'b1, pio_pkg::LED_PORT, 8'hF0);
    port(1'b1, pio_pkg::CTRL_PORT, 8'hFF);
    port(1'b0, pio_pkg::CTRL_PORT, 8'h00);
    chk("status", 8'hF7, rdata);
    @(posedge pclk);
    in_strobe <= 8'h00;
    presetn <= 1'b0;
    @(negedge pclk);
    chk("led", 8'h00, led);
    chk_oe(8'h00);
    chk("irq", 1'b0, irq);
    @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 8; p++) port(1'b0, 3'(p), 8'h00);
    port(1'b0, pio_pkg::CTRL_PORT, 8'h00);
    chk("status", 8'hFF, rdata);
    chk("led", 8'h00, led);
    final_report();
  end
endmodule

// ### bench/pio_ext_model.sv
`timescale 1ns/10ps
module pio_ext_model (
  input wire pio_pkg::port_bytes_t pio_out,
  input wire pio_pkg::port_bytes_t pio_oe_n,
  input wire logic [7:0] ext_mode,
  input wire pio_pkg::port_bytes_t ext_val,
  output logic [7:0] drive_en_n,
  output pio_pkg::port_bytes_t pio_in
);
  // Equipment wanting output pulls the port's enable low
  assign drive_en_n = ~ext_mode;
  // Floated port: equipment drives its own value onto the lines
  always_comb begin
    for (int n = 0; n < pio_pkg::NPORTS; n++) begin
      for (int b = 0; b < 8; b++) begin
        if (pio_oe_n[n][b] == 1'b0) begin
          pio_in[n][b] = pio_out[n][b];
        end else begin
          pio_in[n][b] = ext_val[n][b];
        end
      end
    end
  end
endmodule

// ### rtl/out_port_bank.sv
`timescale 1ns/10ps
module out_port_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  output pio_pkg::port_bytes_t q
);

  pio_pkg::port_bytes_t bank_r;

  assign q = bank_r;

  // Whole bank, control byte and LED byte included, clears on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_r <= {pio_pkg::NPORTS{pio_pkg::OUT_RST}};
    end else if (wr_en) begin
      bank_r[wr_idx] <= wr_data;
    end
  end

endmodule

// ### rtl/parallel_io.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module parallel_io (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pio_pkg::port_bytes_t pio_in,
  output pio_pkg::port_bytes_t pio_out,
  output pio_pkg::port_bytes_t pio_oe_n,
  input wire logic [7:0] drive_en_n,
  input wire logic [7:0] in_strobe,
  input wire logic [2:0] sw3_closed,
  input wire logic [7:0] sw8_closed,
  input wire logic [1:0] opto_current,
  output logic [7:0] led,
  output logic [1:0] relay_energize,
  output logic irq
);

  pio_pkg::apb_req_s req;
  pio_pkg::apb_phase_s ph;
  pio_pkg::port_bytes_t out_q;
  pio_pkg::port_bytes_t in_latch_r;
  logic [7:0] strobe_q_r;
  logic [7:0] full_r;
  logic [7:0] full_nxt;
  logic [7:0] int_sts_r;
  logic [7:0] int_sts_nxt;
  logic [7:0] int_en_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign ph = '{sel: psel, en: penable};

  // Bus decode
  wire setup_ph = ph.sel && !ph.en;
  wire access_ph = ph.sel && ph.en;
  wire hit_port = pio_pkg::is_port(req.addr);
  wire [2:0] pidx = pio_pkg::port_of(req.addr);
  wire hit_sts = req.addr == pio_pkg::INT_STATUS;
  wire hit_en = req.addr == pio_pkg::INT_ENABLE;
  wire hit_clr = req.addr == pio_pkg::INT_CLEAR;
  wire mapped = hit_port || hit_sts || hit_en || hit_clr;
  wire rd_only_bad = hit_sts && req.write;
  wire wr_only_bad = hit_clr && !req.write;
  wire bad = !mapped || rd_only_bad || wr_only_bad;
  wire fire = access_ph && pready;
  wire wr_ok = fire && req.write && !bad;
  wire rd_ok = fire && !req.write && !bad;
  wire port_wr = wr_ok && hit_port;
  wire port_rd = rd_ok && hit_port;
  wire en_wr = wr_ok && hit_en;
  wire clr_wr = wr_ok && hit_clr;

  assign pready = access_ph;
  assign pslverr = access_ph && bad;
  assign prdata = prdata_r;

  out_port_bank u_bank (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(port_wr),
    .wr_idx(pidx),
    .wr_data(req.wdata[7:0]),
    .q(out_q)
  );

  // Output drive control
  wire [7:0] ctrl = out_q[pio_pkg::CTRL_PORT];
  logic [7:0] soft_en;
  logic [7:0] drv_en;

  always_comb begin
    soft_en = ctrl;
    soft_en[pio_pkg::CTRL_PORT] = 1'b0;
  end

  assign drv_en = soft_en | ~drive_en_n;

  genvar g;
  generate
    for (g = 0; g < pio_pkg::NPORTS; g++) begin : g_pins
      assign pio_oe_n[g] = {8{~drv_en[g]}};
    end
  endgenerate

  assign pio_out = out_q;
  assign led = out_q[pio_pkg::LED_PORT];
  // Relay coil on for a 0 bit
  assign relay_energize =
    ~out_q[pio_pkg::RELAY_PORT][pio_pkg::RELAY_W-1:0];

  // Line levels seen by the input side
  pio_pkg::port_bytes_t line_val;

  always_comb begin
    line_val = pio_in;
    // Closed switch grounds its line
    line_val[pio_pkg::SW_PORT][pio_pkg::SW3_W-1:0] =
      pio_in[pio_pkg::SW_PORT][pio_pkg::SW3_W-1:0] & ~sw3_closed;
    // Lit opto pulls its bit low, else pull-up gives 1
    line_val[pio_pkg::SW_PORT][pio_pkg::OPTO_LSB +: pio_pkg::OPTO_W] =
      ~opto_current;
    line_val[pio_pkg::LED_PORT] =
      pio_in[pio_pkg::LED_PORT] & ~sw8_closed;
  end

  wire [7:0] strobe_rise = in_strobe & ~strobe_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q_r <= 8'h00;
    end else begin
      strobe_q_r <= in_strobe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_latch_r <= {pio_pkg::NPORTS{8'h00}};
    end else begin
      for (int i = 0; i < pio_pkg::NPORTS; i++) begin
        if (strobe_rise[i]) begin
          in_latch_r[i] <= line_val[i];
        end
      end
    end
  end

  // Full flags: a read empties, a new strobe in the same cycle wins
  wire [7:0] rd_onehot = port_rd ? (8'h01 << pidx) : 8'h00;

  assign full_nxt = (full_r & ~rd_onehot) | strobe_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_r <= pio_pkg::FULL_RST;
    end else begin
      full_r <= full_nxt;
    end
  end

  // Interrupt status: sticky, write-one clear, set wins
  wire [7:0] clr_mask = clr_wr ? req.wdata[7:0] : 8'h00;

  assign int_sts_nxt = (int_sts_r & ~clr_mask) | strobe_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sts_r <= 8'h00;
      int_en_r <= pio_pkg::INT_EN_RST;
    end else begin
      int_sts_r <= int_sts_nxt;
      if (en_wr) begin
        int_en_r <= req.wdata[7:0];
      end
    end
  end

  assign irq = |(int_sts_r & int_en_r);

  // Read data; switch and opto ports read live, status port gives flags
  wire live_port = (pidx == pio_pkg::SW_PORT) || (pidx == pio_pkg::LED_PORT);
  wire [7:0] port_byte =
    (pidx == pio_pkg::CTRL_PORT) ? ~full_r :
    live_port ? line_val[pidx] : in_latch_r[pidx];

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (hit_port) begin
      prdata_nxt[7:0] = port_byte;
    end else if (hit_sts) begin
      prdata_nxt[7:0] = int_sts_r;
    end else if (hit_en) begin
      prdata_nxt[7:0] = int_en_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !req.write) begin
      prdata_r <= prdata_nxt;
    end
  end

  // Checks
  function automatic logic is_port_n(input logic [2:0] n);
    return hit_port && pidx == n;
  endfunction

  sequence s_port_write(logic [2:0] n);
    psel && penable && pwrite && pready && !pslverr && is_port_n(n);
  endsequence

  property p_sw8_reads_low;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_port && pidx == pio_pkg::LED_PORT)
      |=> ((prdata[7:0] & sw8_closed) == 8'h00) || $changed(sw8_closed);
  endproperty
  a_sw8_reads_low: assert property (p_sw8_reads_low)
    else $error("closed switch did not read as 0");

  property p_sw3_lines;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_port && pidx == pio_pkg::SW_PORT)
      ##1 $stable(sw3_closed) |->
      (prdata[2:0] & sw3_closed) == 3'h0;
  endproperty
  a_sw3_lines: assert property (p_sw3_lines)
    else $error("small switch bank not on port 4 low lines");

  property p_led_follows;
    @(posedge pclk) disable iff (!presetn)
    s_port_write(pio_pkg::LED_PORT) |=> led == $past(pwdata[7:0]);
  endproperty
  a_led_follows: assert property (p_led_follows)
    else $error("LEDs do not show the port 7 output value");

  property p_out7_isolated;
    @(posedge pclk) disable iff (!presetn)
    !(port_wr && pidx == pio_pkg::LED_PORT) |=>
      pio_out[pio_pkg::LED_PORT] == $past(pio_out[pio_pkg::LED_PORT]);
  endproperty
  a_out7_isolated: assert property (p_out7_isolated)
    else $error("port 7 output changed without a write");

  property p_opto_bits;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_port && pidx == pio_pkg::SW_PORT)
      ##1 $stable(opto_current) |-> prdata[4:3] == ~opto_current;
  endproperty
  a_opto_bits: assert property (p_opto_bits)
    else $error("opto bits wrong on port 4");

  property p_relay;
    @(posedge pclk) disable iff (!presetn)
    s_port_write(pio_pkg::RELAY_PORT) |=>
      relay_energize == ~$past(pwdata[1:0]);
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay drive does not follow inverted bits 0 and 1");

  property p_reset_clears;
    @(posedge pclk) !presetn |-> led == 8'h00 && ctrl == 8'h00;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset did not clear LED and control ports");

  property p_float_when_off;
    @(posedge pclk) disable iff (!presetn)
    (ctrl == 8'h00 && drive_en_n == 8'hFF) |->
      pio_oe_n == {pio_pkg::NPORTS{8'hFF}};
  endproperty
  a_float_when_off: assert property (p_float_when_off)
    else $error("a port drives with its enables off");

  property p_ctrl_bit;
    @(posedge pclk) disable iff (!presetn)
    s_port_write(pio_pkg::CTRL_PORT) ##1 drive_en_n[0] |->
      pio_oe_n[0][0] == ~$past(pwdata[0], 1);
  endproperty
  a_ctrl_bit: assert property (p_ctrl_bit)
    else $error("control bit 0 does not steer port 0 drivers");

  property p_port6_no_self;
    @(posedge pclk) disable iff (!presetn)
    drive_en_n[pio_pkg::CTRL_PORT] |-> pio_oe_n[pio_pkg::CTRL_PORT] == 8'hFF;
  endproperty
  a_port6_no_self: assert property (p_port6_no_self)
    else $error("control port enabled by its own bit");

  property p_ext_enable;
    @(posedge pclk) disable iff (!presetn)
    !drive_en_n[0] |-> pio_oe_n[0] == 8'h00;
  endproperty
  a_ext_enable: assert property (p_ext_enable)
    else $error("external drive-enable did not turn port on");

  property p_read_empties;
    @(posedge pclk) disable iff (!presetn)
    (port_rd && !strobe_rise[pidx]) |=> !full_r[$past(pidx)];
  endproperty
  a_read_empties: assert property (p_read_empties)
    else $error("reading an input port left it full");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_port && pidx == pio_pkg::CTRL_PORT)
      |=> prdata[7:0] == ~$past(full_r);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status port does not show inverted full flags");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    s_port_write(3'h3) |=> pio_out[3] == $past(pwdata[7:0]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("output port 3 missed a write");

  property p_strobe_fills;
    @(posedge pclk) disable iff (!presetn)
    (|strobe_rise) |=> (full_r & $past(strobe_rise)) == $past(strobe_rise);
  endproperty
  a_strobe_fills: assert property (p_strobe_fills)
    else $error("input strobe did not mark its port full");

  property p_refused_write;
    @(posedge pclk) disable iff (!presetn)
    (access_ph && pwrite && pslverr) |=> $stable(out_q) && $stable(int_en_r);
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("refused write changed a register");

endmodule

// ### rtl/pio_pkg.sv
package pio_pkg;

  localparam int NPORTS = 8;
  localparam int AW = 8;

  localparam logic [7:0] PORT_BASE = 8'h00;
  localparam logic [7:0] INT_STATUS = 8'h20;
  localparam logic [7:0] INT_ENABLE = 8'h24;
  localparam logic [7:0] INT_CLEAR = 8'h28;

  localparam logic [2:0] RELAY_PORT = 3'h1;
  localparam logic [2:0] SW_PORT = 3'h4;
  localparam logic [2:0] CTRL_PORT = 3'h6;
  localparam logic [2:0] LED_PORT = 3'h7;

  localparam int SW3_W = 3;
  localparam int OPTO_LSB = 3;
  localparam int OPTO_W = 2;
  localparam int RELAY_W = 2;

  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] FULL_RST = 8'h00;

  typedef logic [7:0] byte_t;
  typedef logic [NPORTS-1:0][7:0] port_bytes_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_s;

  typedef struct packed {
    logic sel;
    logic en;
  } apb_phase_s;

  function automatic logic is_port(input logic [AW-1:0] a);
    return (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] port_of(input logic [AW-1:0] a);
    return a[4:2];
  endfunction

endpackage
